// ### src/sdmi_core.sv
// Mode register, burst column sequencer and read latency control.
`timescale 1ns/1ps
`include "sdmi_cfg.svh"
module sdmi_core #(
  parameter int COLS = 10,
  parameter int DQW  = 16
) (
  input  wire logic               CLK_I,
  input  wire logic               RSTN_I,
  input  wire logic               CKE_I,
  input  wire sdmi_pkg::sdmi_cmd_type CMD_I,
  input  wire logic [1:0]         BANK_I,
  input  wire logic [11:0]        ADDR_I,
  input  wire logic [DQW-1:0]     RD_DATA_I,
  output logic      [COLS-1:0]    COL_O,
  output logic                    COL_VALID_O,
  output logic                    COL_WRITE_O,
  output logic      [DQW-1:0]     DQ_O,
  output logic                    DQ_OE_O,
  output logic                    DQ_VALID_O,
  output logic      [11:0]        MODE_O,
  output logic                    MODE_BAD_O,
  output logic                    FIFO_FULL_O
);
  import sdmi_pkg::*;
  // ---------------------------------------------------------------------------
  // State
  // ---------------------------------------------------------------------------
  typedef struct packed {
    sdmi_state_type    st;
    logic [11:0]       mode;
    logic              bad;
    logic [COLS-1:0]   start;
    logic [COLS-1:0]   idx;
    logic [COLS:0]     left;
    logic              wr;
    logic              full;
    logic [2:0]        vl_pipe;
    logic [COLS-1:0]   col;
    logic              col_v;
    logic              col_w;
    logic [DQW-1:0]    dq;
    logic              oe;
    logic              dv;
  } sdmi_core_type;
  sdmi_core_type s_q, s_d;

  logic [COLS-1:0] f_col;
  logic            f_valid, f_ready, f_push;

  // Column for step i of a burst, wrapped inside the aligned block.
  function automatic logic [COLS-1:0] burst_col(
    input logic [COLS-1:0] start, input logic [COLS-1:0] i,
    input logic [2:0] blc, input logic interleave);
    logic [COLS-1:0] mask;
    logic [COLS-1:0] off;
    mask = '0;
    case (blc)
      `SDMI_BLC_2: mask = COLS'(1);
      `SDMI_BLC_4: mask = COLS'(3);
      `SDMI_BLC_8: mask = COLS'(7);
      `SDMI_BLC_PAGE: mask = '1;
      default: mask = '0;
    endcase
    if (interleave && blc != `SDMI_BLC_PAGE) off = start ^ i;
    else off = start + i;
    return (start & ~mask) | (off & mask);
  endfunction : burst_col

  function automatic logic [COLS:0] burst_len(input logic [2:0] blc);
    case (blc)
      `SDMI_BLC_1: return (COLS+1)'(1);
      `SDMI_BLC_2: return (COLS+1)'(2);
      `SDMI_BLC_4: return (COLS+1)'(4);
      `SDMI_BLC_8: return (COLS+1)'(8);
      default: return (COLS+1)'(1) << COLS;
    endcase
  endfunction : burst_len

  logic [2:0] blc, lat;
  assign blc = s_q.mode[`SDMI_M_BL_MSB:`SDMI_M_BL_LSB];
  assign lat = s_q.mode[`SDMI_M_LAT_MSB:`SDMI_M_LAT_LSB];
  assign f_push = (s_q.st != SDMI_IDLE) && f_ready;

  // ---------------------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------------------
  always_comb begin
    logic [11:0] m;
    logic        cmd_ok;
    logic        quiet;
    m = ADDR_I;
    cmd_ok = CKE_I;
    quiet = cmd_ok && CMD_I == SDMI_CMD_MODE;
    s_d = s_q;
    s_d.vl_pipe = {s_q.vl_pipe[1:0], 1'b0};
    if (cmd_ok && CMD_I == SDMI_CMD_MODE && BANK_I == 2'b00) begin
      s_d.mode = m;
      s_d.bad = (m[`SDMI_M_OPHI_BIT:`SDMI_M_OPLO_BIT] != 2'b00)
        || (m[`SDMI_M_LAT_MSB:`SDMI_M_LAT_LSB] != `SDMI_LAT_2
            && m[`SDMI_M_LAT_MSB:`SDMI_M_LAT_LSB] != `SDMI_LAT_3)
        || (m[2:0] == 3'h4 || m[2:0] == 3'h5 || m[2:0] == 3'h6)
        || (m[2:0] == `SDMI_BLC_PAGE && m[`SDMI_M_ORDER_BIT]);
      s_d.st = SDMI_IDLE;
    end else if (cmd_ok && CMD_I == SDMI_CMD_TERM) begin
      s_d.st = SDMI_IDLE;
    end else if (cmd_ok && (CMD_I == SDMI_CMD_READ
                         || CMD_I == SDMI_CMD_WRITE)) begin
      s_d.wr = (CMD_I == SDMI_CMD_WRITE);
      s_d.start = ADDR_I[COLS-1:0];
      s_d.idx = '0;
      s_d.st = s_d.wr ? SDMI_WRITE : SDMI_READ;
      if (s_d.wr && s_q.mode[`SDMI_M_WB_BIT]) s_d.left = (COLS+1)'(1);
      else s_d.left = burst_len(blc);
    end else if (f_push) begin
      s_d.idx = s_q.idx + COLS'(1);
      s_d.left = s_q.left - (COLS+1)'(1);
      if (s_q.left == (COLS+1)'(1)) s_d.st = SDMI_IDLE;
    end
    // Each queued read column starts the latency pipeline; the stage it
    // enters sets how many edges pass before its data is marked valid.
    if (f_push && s_q.st == SDMI_READ && !quiet) begin
      if (lat == `SDMI_LAT_3) s_d.vl_pipe[1] = 1'b1;
      else s_d.vl_pipe[2] = 1'b1;
    end
    // Any mode command floats the data pins at once and clears the latency pipeline; the column queue keeps its entries.
    if (quiet) s_d.vl_pipe = '0;
    s_d.col_v = f_valid;
    s_d.col = f_col;
    s_d.col_w = s_q.wr;
    // Drive starts one edge before the first valid word.
    s_d.dv = s_q.vl_pipe[2] && !quiet;
    s_d.oe = s_d.vl_pipe[2] | s_d.dv;
    s_d.full = !f_ready;
    s_d.dq = RD_DATA_I;
  end

  always_ff @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      s_q <= '0;
      s_q.mode <= `SDMI_MODE_RESET;
    end else begin
      s_q <= s_d;
    end
  end

  // ---------------------------------------------------------------------------
  // Column queue
  // ---------------------------------------------------------------------------
  sdmi_fifo #(.WIDTH(COLS), .DEPTH(`SDMI_FIFO_DEPTH)) u_fifo (
    .clk_i      (CLK_I),
    .rstn_i     (RSTN_I),
    .in_valid_i (s_q.st != SDMI_IDLE),
    .in_ready_o (f_ready),
    .in_data_i  (burst_col(s_q.start, s_q.idx, blc,
                           s_q.mode[`SDMI_M_ORDER_BIT])),
    .out_valid_o(f_valid),
    .out_ready_i(1'b1),
    .out_data_o (f_col)
  );

  assign COL_O       = s_q.col;
  assign COL_VALID_O = s_q.col_v;
  assign COL_WRITE_O = s_q.col_w;
  assign DQ_O        = s_q.dq;
  assign DQ_OE_O     = s_q.oe;
  assign DQ_VALID_O  = s_q.dv;
  assign MODE_O      = s_q.mode;
  assign MODE_BAD_O  = s_q.bad;
  // Registered, so it trails the queue count by one cycle.
  assign FIFO_FULL_O = s_q.full;

  // ---------------------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------------------
  a_mode_hold: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
    !(CKE_I && CMD_I == SDMI_CMD_MODE && BANK_I == 2'b00) |=> $stable(MODE_O))
    else $error("mode word changed without a load");
  a_mode_load: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
    (CKE_I && CMD_I == SDMI_CMD_MODE && BANK_I == 2'b00)
      |=> MODE_O == $past(ADDR_I))
    else $error("mode word not loaded");
  a_load_quiet: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
    (CKE_I && CMD_I == SDMI_CMD_MODE) |=> ##1 !DQ_OE_O)
    else $error("outputs driven after mode load");
  a_single_col: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
    (s_q.st != SDMI_IDLE && blc == `SDMI_BLC_1)
      |-> burst_col(s_q.start, s_q.idx, blc, 1'b1) == s_q.start)
    else $error("burst of one left its column");
  a_op_bad: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
    (CKE_I && CMD_I == SDMI_CMD_MODE && BANK_I == 2'b00 && ADDR_I[7])
      |=> MODE_BAD_O)
    else $error("reserved operating mode not flagged");
  a_valid_lat: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
    (CKE_I && CMD_I == SDMI_CMD_READ && lat == `SDMI_LAT_2)
      ##1 !(CKE_I && CMD_I == SDMI_CMD_MODE)
      ##1 !(CKE_I && CMD_I == SDMI_CMD_MODE) |-> ##1 DQ_VALID_O)
    else $error("read data late for latency two");
  a_drive_first: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
    $rose(DQ_VALID_O) |-> $past(DQ_OE_O))
    else $error("data marked valid before drive began");
endmodule : sdmi_core

// ### inc/sdmi_cfg.svh
// Constants for the SDRAM mode and burst sequencing block.
`ifndef SDMI_CFG_SVH
`define SDMI_CFG_SVH
// -----------------------------------------------------------------------------
// Mode word fields
// -----------------------------------------------------------------------------
`define SDMI_M_BL_LSB      0
`define SDMI_M_BL_MSB      2
`define SDMI_M_ORDER_BIT   3
`define SDMI_M_LAT_LSB     4
`define SDMI_M_LAT_MSB     6
`define SDMI_M_OPLO_BIT    7
`define SDMI_M_OPHI_BIT    8
`define SDMI_M_WB_BIT      9
`define SDMI_BL_1          3'h1
`define SDMI_BL_2          3'h1
`define SDMI_BLC_1         3'h0
`define SDMI_BLC_2         3'h1
`define SDMI_BLC_4         3'h2
`define SDMI_BLC_8         3'h3
`define SDMI_BLC_PAGE      3'h7
`define SDMI_LAT_2         3'h2
`define SDMI_LAT_3         3'h3
`define SDMI_MODE_RESET    12'h0_022
`define SDMI_FIFO_DEPTH    8
`define SDMI_PAGE_X16      512
`endif

// ### inc/sdmi_pkg.sv
// Types for the SDRAM mode and burst sequencing block.
package sdmi_pkg;
  typedef enum logic [2:0] {
    SDMI_CMD_NOP   = 3'h0,
    SDMI_CMD_MODE  = 3'h1,
    SDMI_CMD_READ  = 3'h2,
    SDMI_CMD_WRITE = 3'h3,
    SDMI_CMD_TERM  = 3'h4,
    SDMI_CMD_OTHER = 3'h5
  } sdmi_cmd_type;
  typedef enum logic [1:0] {
    SDMI_IDLE  = 2'b00,
    SDMI_READ  = 2'b01,
    SDMI_WRITE = 2'b10
  } sdmi_state_type;
endpackage : sdmi_pkg

// ### src/sdmi_fifo.sv
// Synchronous valid/ready FIFO for column addresses.
`timescale 1ns/1ps
module sdmi_fifo #(
  parameter int WIDTH = 10,
  parameter int DEPTH = 8
) (
  input  wire logic             clk_i,
  input  wire logic             rstn_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic      [WIDTH-1:0] out_data_o
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [AW-1:0] wr;
    logic [AW-1:0] rd;
    logic [AW:0]   cnt;
  } sdmi_fifo_type;
  sdmi_fifo_type    s_q, s_d;
  logic [WIDTH-1:0] mem [DEPTH];
  logic             push, pop;
  assign in_ready_o  = (s_q.cnt != (AW+1)'(DEPTH));
  assign out_valid_o = (s_q.cnt != '0);
  assign out_data_o  = mem[s_q.rd];
  assign push = in_valid_i && in_ready_o;
  assign pop  = out_valid_o && out_ready_i;
  always_comb begin
    s_d = s_q;
    if (push) s_d.wr = AW'((32'(s_q.wr) + 1) % DEPTH);
    if (pop) s_d.rd = AW'((32'(s_q.rd) + 1) % DEPTH);
    s_d.cnt = s_q.cnt + (AW+1)'(push) - (AW+1)'(pop);
  end
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) s_q <= '0;
    else s_q <= s_d;
  end
  always_ff @(posedge clk_i) begin
    if (push) mem[s_q.wr] <= in_data_i;
  end
endmodule : sdmi_fifo

// ### verification/sdmi_ctl_model.sv
// Memory controller model that runs the power-up sequence.
`timescale 1ns/1ps
module sdmi_ctl_model #(
  parameter int T_INIT = 20000,
  parameter int T_WAIT = 4
) (
  input  wire logic                   clk_i,
  input  wire logic                   rstn_i,
  input  wire sdmi_pkg::sdmi_cmd_type req_cmd_i,
  input  wire logic [1:0]             req_bank_i,
  input  wire logic [11:0]            req_addr_i,
  output logic                        cke_o,
  output sdmi_pkg::sdmi_cmd_type      cmd_o,
  output logic [1:0]                  bank_o,
  output logic [11:0]                 addr_o,
  output logic                        done_o
);
  import sdmi_pkg::*;
  sdmi_cmd_type c = SDMI_CMD_NOP;
  logic [11:0]  a = 12'h5a5;
  // Address toggles during waits so nothing leans on a stale value.
  task automatic step(input sdmi_cmd_type k, input int n);
    c <= k;
    @(posedge clk_i);
    repeat (n) begin
      c <= SDMI_CMD_NOP;
      a <= ~a;
      @(posedge clk_i);
    end
  endtask : step
  assign cmd_o  = done_o ? req_cmd_i : c;
  assign bank_o = done_o ? req_bank_i : 2'h0;
  assign addr_o = done_o ? req_addr_i : a;
  initial begin
    cke_o = 1'b0;
    done_o = 1'b0;
    @(posedge rstn_i);
    @(posedge clk_i);
    step(SDMI_CMD_NOP, T_INIT / 2);
    cke_o <= 1'b1;
    step(SDMI_CMD_NOP, T_INIT / 2);
    step(SDMI_CMD_OTHER, T_WAIT);
    repeat (2) step(SDMI_CMD_OTHER, T_WAIT);
    a <= 12'h032;
    step(SDMI_CMD_MODE, T_WAIT);
    done_o <= 1'b1;
  end
endmodule : sdmi_ctl_model

// ### verification/sdram_init_and_mode_setup_test.sv
// Self-checking bench for the mode and burst sequencing block.
`timescale 1ns/1ps
module sdram_init_and_mode_setup_test;
  import sdmi_pkg::*;
  typedef struct {
    logic [11:0] m;
    logic [9:0]  s;
    int          n;
    logic        w;
  } sdmi_row_type;
  logic         clk = 0, rstn = 0, cke, done, oe, dv, cv, cw, bad, full;
  logic [9:0]   col;
  logic [1:0]   bank, rbank = 0;
  logic [11:0]  addr, raddr = 0, mode;
  logic [15:0]  rd = 0, dq;
  sdmi_cmd_type cmd, rcmd = SDMI_CMD_NOP;
  int           n_errors = 0, check_count = 0, cyc = 0;
  // The page burst row is cut by the watch window: 22 columns are seen.
  sdmi_row_type rows [9] = '{'{12'h021, 10'h0d3, 2, 0},
    '{12'h032, 10'h106, 4, 0}, '{12'h02a, 10'h105, 4, 0},
    '{12'h033, 10'h07d, 8, 0}, '{12'h02b, 10'h0f6, 8, 0},
    '{12'h038, 10'h2b7, 1, 0}, '{12'h027, 10'h3fe, 22, 0},
    '{12'h023, 10'h011, 8, 1}, '{12'h223, 10'h011, 1, 1}};
  logic [11:0]  bm [4] = '{12'h024, 12'h0a2, 12'h03f, 12'h052};
  sdmi_ctl_model sdmi_ctl_model_inst (.clk_i(clk), .rstn_i(rstn),
    .req_cmd_i(rcmd), .req_bank_i(rbank), .req_addr_i(raddr),
    .cke_o(cke), .cmd_o(cmd), .bank_o(bank), .addr_o(addr), .done_o(done));
  sdmi_core sdmi_core_inst (.CLK_I(clk), .RSTN_I(rstn), .CKE_I(cke),
    .CMD_I(cmd), .BANK_I(bank), .ADDR_I(addr), .RD_DATA_I(rd),
    .COL_O(col), .COL_VALID_O(cv), .COL_WRITE_O(cw), .DQ_O(dq),
    .DQ_OE_O(oe), .DQ_VALID_O(dv), .MODE_O(mode), .MODE_BAD_O(bad),
    .FIFO_FULL_O(full));
  initial begin
    forever #2.5 clk = ~clk;
  end
  // A hang counts as a mismatch and still reaches the report.
  always @(posedge clk) begin
    rd <= rd + 16'h0001;
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      n_errors++;
      wrap_up();
    end
  end
  task automatic wrap_up();
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : wrap_up
  task automatic chk(string n, logic [11:0] e, logic [11:0] g);
    check_count++;
    if (g !== e) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  function automatic logic [9:0] ex(logic [9:0] s, logic [2:0] b,
                                    logic o, int i);
    logic [9:0] k;
    k = (b == 3'h7) ? 10'h3ff : (10'h001 << b) - 10'h001;
    if (o && b != 3'h7) return (s & ~k) | ((s ^ i[9:0]) & k);
    return (s & ~k) | ((s + i[9:0]) & k);
  endfunction : ex
  task automatic issue(sdmi_cmd_type c, logic [1:0] b, logic [11:0] a);
    @(posedge clk);
    rcmd <= c;
    rbank <= b;
    raddr <= a;
    @(posedge clk);
    rcmd <= SDMI_CMD_NOP;
  endtask : issue
  task automatic load(logic [11:0] m);
    issue(SDMI_CMD_MODE, 2'h0, m);
    repeat (3) @(posedge clk);
    @(negedge clk);
  endtask : load
  task automatic run(sdmi_row_type r);
    int got, k, cf, df, of;
    got = 0;
    cf = -1;
    df = -1;
    of = -1;
    load(r.m);
    chk("mode", r.m, mode);
    chk("oe", 12'h000, {11'h0, oe});
    issue(r.w ? SDMI_CMD_WRITE : SDMI_CMD_READ, 2'h0, {2'h0, r.s});
    for (k = 0; k < 24; k++) begin
      @(negedge clk);
      if (oe === 1'b1 && of < 0) of = k;
      if (dv === 1'b1 && df < 0) df = k;
      if (cv === 1'b1) begin
        if (cf < 0) cf = k;
        chk("col", {2'h0, ex(r.s, r.m[2:0], r.m[3], got)},
            {2'h0, col});
        chk("wr", {11'h0, r.w}, {11'h0, cw});
        got++;
      end
      if (dv === 1'b1) chk("dq", 12'(rd - 16'h0001), dq[11:0]);
    end
    if (r.n > 0) chk("len", 12'(r.n), 12'(got));
    chk("first", 12'h002, 12'(cf));
    if (!r.w) chk("lat", {9'h0, r.m[6:4]}, 12'(df));
    if (!r.w) chk("drv", {9'h0, r.m[6:4]} - 12'h001, 12'(of));
    if (r.w) chk("drv", 12'hfff, 12'(of));
    issue(SDMI_CMD_TERM, 2'h0, 12'h000);
    repeat (8) @(posedge clk);
  endtask : run
  // ---------------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------------
  initial begin
    repeat (12) @(posedge clk);
    rstn <= 1'b1;
    @(negedge clk);
    chk("mode", 12'h022, mode);
    while (done !== 1'b1) @(posedge clk);
    @(negedge clk);
    chk("mode", 12'h032, mode);
    foreach (rows[i]) run(rows[i]);
    issue(SDMI_CMD_MODE, 2'h1, 12'h033);
    @(negedge clk);
    chk("mode", 12'h223, mode);
    foreach (bm[i]) begin
      load(bm[i]);
      chk("bad", 12'h001, {11'h0, bad});
    end
    load(12'h032);
    chk("bad", 12'h000, {11'h0, bad});
    // A long page burst streams through the column queue, one word a cycle;
    // a stuck queue would fill and break the column run.
    load(12'h027);
    issue(SDMI_CMD_READ, 2'h0, 12'h3f8);
    repeat (2) @(negedge clk);
    for (int i = 0; i < 40; i++) begin
      @(negedge clk);
      chk("fifo_full", 12'h000, {11'h0, full});
      chk("fifo_out", {2'h1, 10'h3f8 + 10'(i)}, {1'b0, cv, col});
    end
    issue(SDMI_CMD_TERM, 2'h0, 12'h000);
    repeat (8) @(posedge clk);
    @(negedge clk);
    chk("fifo_vld", 12'h000, {11'h0, cv});
    @(posedge clk);
    rstn <= 1'b0;
    repeat (2) @(negedge clk);
    chk("mode", 12'h022, mode);
    chk("oe", 12'h000, {11'h0, oe});
    wrap_up();
  end
endmodule : sdram_init_and_mode_setup_test
